// ==== pkg/ivam_pkg.sv ====
// Purpose: Shared constants and types for the interrupt vector address map
// Assumes: 20-bit byte address space, program memory read port of 16 bits
// Notes:   Tags below mark the logic that carries each rule
// What this block does
// - Each vector entry spans four bytes
// - Accepted interrupt fetches entry, continues at it
// - Fixed table spans FFFDC to FFFFF
// - Undefined-opcode trap uses entry FFFDC
// - Overflow trap uses entry FFFE0
// - Breakpoint FFFE4, relocatable when FFFE7 reads FF
// - Other fixed entries mapped from FFFE8 to FFFFC
// - Fixed entry high bytes form flash ID code
// - Relocatable table: 256 bytes from base register
// - Even base fetches faster than odd base
// - Number 0 breakpoint; numbers 1-3 reserved
// - External pin 3 uses number 4
// - Capture/compare 0 uses number 5
// - Capture/compare 1 shares number 6 with I2C
// - Capture base timer shares 7 with lines
// - Serial 4 and pin 5 share number 8
// - Serial 3 and pin 4 share number 9
// - Serial 2 bus collision uses number 10
// - DMA channels 0 and 1 use 11, 12
// - Key input 13, converter 14
// - Serial 2 tx 15, rx 16, serial 0 tx 17
// - Relocatable entry n sits at base plus 4n
// - Watchdog and oscillation stop share one vector
// - Two select bits pick sources for 8, 9
// - Two more select bits pick sources for 6, 7
package ivam_pkg;

  localparam int unsigned ADDR_W = 20;
  localparam int unsigned SWN_W  = 6;

  // Fixed vector entries
  localparam logic [19:0] FIX_UND   = 20'hF_FFDC;
  localparam logic [19:0] FIX_OVF   = 20'hF_FFE0;
  localparam logic [19:0] FIX_BRK   = 20'hF_FFE4;
  localparam logic [19:0] FIX_ADM   = 20'hF_FFE8;
  localparam logic [19:0] FIX_SSTEP = 20'hF_FFEC;
  localparam logic [19:0] FIX_WDG   = 20'hF_FFF0;
  localparam logic [19:0] FIX_DBG   = 20'hF_FFF4;
  localparam logic [19:0] FIX_NMI   = 20'hF_FFF8;
  localparam logic [19:0] FIX_RST   = 20'hF_FFFC;
  localparam logic [19:0] FIX_LO    = FIX_UND;
  localparam logic [19:0] FIX_HI    = 20'hF_FFFF;
  localparam logic [19:0] BRK_FLAG_ADDR = 20'hF_FFE7;
  localparam logic [7:0]  BRK_RELOC_MARK = 8'hFF;

  // Address steps
  localparam logic [19:0] STEP_BYTE  = 20'h0_0001;
  localparam logic [19:0] STEP_WORD  = 20'h0_0002;
  localparam logic [19:0] ENTRY_HI   = 20'h0_0003;
  localparam logic [19:0] ENTRY_STEP = 20'h0_0004;
  localparam logic [2:0]  LAST_WORD_UNIT = 3'h1;
  localparam logic [2:0]  LAST_BYTE_UNIT = 3'h3;
  localparam logic [2:0]  ID_LAST_ENTRY  = 3'h7;
  localparam int unsigned ID_BYTES = 8;

  // Software interrupt numbers
  localparam logic [5:0] SWN_BRK    = 6'h00;
  localparam logic [5:0] SWN_RSV_HI = 6'h03;
  localparam logic [5:0] SWN_PIN3   = 6'h04;
  localparam logic [5:0] SWN_CC0    = 6'h05;
  localparam logic [5:0] SWN_CC1    = 6'h06;
  localparam logic [5:0] SWN_CTMR   = 6'h07;
  localparam logic [5:0] SWN_SER4   = 6'h08;
  localparam logic [5:0] SWN_SER3   = 6'h09;
  localparam logic [5:0] SWN_COLL   = 6'h0A;
  localparam logic [5:0] SWN_DMA0   = 6'h0B;
  localparam logic [5:0] SWN_DMA1   = 6'h0C;
  localparam logic [5:0] SWN_KEY    = 6'h0D;
  localparam logic [5:0] SWN_ADC    = 6'h0E;
  localparam logic [5:0] SWN_SER2TX = 6'h0F;
  localparam logic [5:0] SWN_SER2RX = 6'h10;
  localparam logic [5:0] SWN_SER0TX = 6'h11;

  typedef enum logic [3:0] {
    SRC_UND, SRC_OVF, SRC_BRK, SRC_ADM, SRC_SSTEP,
    SRC_WDG, SRC_DBG, SRC_NMI, SRC_RST, SRC_SOFT
  } ivam_src_e;

  typedef enum logic [4:0] {
    PER_NONE, PER_BRK, PER_RSV, PER_PIN3, PER_CC0, PER_CC1, PER_I2C,
    PER_CTMR, PER_LINES, PER_SER4, PER_PIN5, PER_SER3, PER_PIN4, PER_COLL,
    PER_DMA0, PER_DMA1, PER_KEY, PER_ADC, PER_SER2TX, PER_SER2RX,
    PER_SER0TX, PER_OTHER
  } ivam_per_e;

  typedef struct packed {
    ivam_src_e        src;
    logic [SWN_W-1:0] swn;
  } ivam_req_s;

  typedef struct packed {
    logic sel_serial3_or_pin4;
    logic sel_serial4_or_pin5;
    logic sel_capcmp1_or_i2c;
    logic sel_captimer_or_lines;
  } ivam_sel_s;

endpackage

// ==== rtl/ivam_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input changes slowly relative to sys_clk
// Notes:   Output follows once stages two and three agree
`timescale 1ns/1ps
module ivam_sync (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic din,
  output logic      dout_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Shift chain, first stage feeds only the second
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      dout_q <= 1'b0;
    end
    else if (ce)
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        dout_q <= s3_q; // Accept only a settled level
    end
  end
endmodule // ivam_sync

// ==== rtl/ivam_addr.sv ====
// Purpose: Forms the first byte address of a vector entry
// Assumes: Request and base are stable while used
// Notes:   Pure combinational lookup
`timescale 1ns/1ps
module ivam_addr
  import ivam_pkg::*;
(
  input  ivam_req_s         req,
  input  wire logic [19:0]  base,
  input  wire logic         brk_reloc,
  output logic [19:0]       addr,
  output logic              word_ok
);
  // Fixed entry start for a hardware or trap source
  function automatic logic [19:0] fixed_addr(input ivam_src_e s);
    unique case (s)
      SRC_UND:   fixed_addr = FIX_UND;
      SRC_OVF:   fixed_addr = FIX_OVF;
      SRC_BRK:   fixed_addr = FIX_BRK;
      SRC_ADM:   fixed_addr = FIX_ADM;
      SRC_SSTEP: fixed_addr = FIX_SSTEP;
      SRC_WDG:   fixed_addr = FIX_WDG;
      SRC_DBG:   fixed_addr = FIX_DBG;
      SRC_NMI:   fixed_addr = FIX_NMI;
      SRC_RST:   fixed_addr = FIX_RST;
      default:   fixed_addr = FIX_UND;
    endcase
  endfunction

  // Relocatable entries sit at base plus four times the number
  always_comb
  begin
    if (req.src == SRC_SOFT)
      addr = base + {12'h000, req.swn, 2'b00};
    else if (req.src == SRC_BRK && brk_reloc)
      addr = base + {12'h000, SWN_BRK, 2'b00};
    else
      addr = fixed_addr(req.src);
    word_ok = ~addr[0];
  end
endmodule // ivam_addr

// ==== rtl/ivam_top.sv ====
// Purpose: Vector entry fetch for accepted interrupts
// Assumes: Memory port returns 16 bits on word reads, low byte on byte reads
// Notes:   Even entry addresses take two word reads, odd ones four byte reads
`timescale 1ns/1ps
module ivam_top
  import ivam_pkg::*;
#(
  parameter bit FLASH_VERSION = 1'b1
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        req_valid,
  input  ivam_req_s        req,
  input  wire logic [19:0] vector_base_register,
  input  ivam_sel_s        sel,
  input  wire logic        osc_stop_detect_flag,
  input  wire logic        id_start,
  output logic             mem_rd_req,
  output logic [19:0]      mem_addr_q,
  output logic             mem_word_q,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  output logic             busy,
  output logic             done_q,
  output logic [19:0]      handler_addr_q,
  output ivam_per_e        periph_src_q,
  output logic             wdg_osc_stop_q,
  output logic [63:0]      id_code_q,
  output logic             id_valid_q
);

  typedef enum logic [1:0] {ST_IDLE, ST_BRK_CHK, ST_FETCH, ST_ID_RD} ivam_st_e;

  ivam_st_e    state_q;
  ivam_req_s   req_q;
  ivam_req_s   cur_req;
  logic [31:0] vec_q;
  logic [31:0] vec_d;
  logic [2:0]  unit_q;
  logic [2:0]  last_unit;
  logic [19:0] entry_addr;
  logic        entry_word;
  logic        brk_reloc;
  logic        osc_flag_s;
  logic        fetch_ack;
  ivam_per_e   per_d;

  // Oscillation-stop flag comes from the clock circuit, another domain
  ivam_sync u_osc_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .din     (osc_stop_detect_flag),
    .dout_q  (osc_flag_s)
  );

  // Request in flight: live at acceptance, latched afterwards
  assign cur_req = (state_q == ST_IDLE) ? req : req_q;
  // Breakpoint goes relocatable when the flag byte reads all ones
  assign brk_reloc = (state_q == ST_BRK_CHK) && (mem_rdata[7:0] == BRK_RELOC_MARK);

  ivam_addr u_addr (
    .req       (cur_req),
    .base      (vector_base_register),
    .brk_reloc (brk_reloc),
    .addr      (entry_addr),
    .word_ok   (entry_word)
  );

  // Handshake toward program memory
  assign mem_rd_req = (state_q != ST_IDLE);
  assign busy       = (state_q != ST_IDLE);
  assign fetch_ack  = (state_q == ST_FETCH) && mem_ack;
  assign last_unit  = mem_word_q ? LAST_WORD_UNIT : LAST_BYTE_UNIT;

  // Places the returned unit into the entry, lowest address lowest byte
  always_comb
  begin
    vec_d = vec_q;
    if (mem_word_q)
      vec_d[16*unit_q[0] +: 16] = mem_rdata;
    else
      vec_d[8*unit_q[1:0] +: 8] = mem_rdata[7:0];
  end

  // Peripheral source behind a software number, shared ones by select bits
  always_comb
  begin
    per_d = PER_OTHER;
    if (cur_req.src != SRC_SOFT)
      per_d = PER_NONE;
    else if (cur_req.swn == SWN_BRK)
      per_d = PER_BRK;
    else if (cur_req.swn <= SWN_RSV_HI)
      per_d = PER_RSV;
    else
    begin
      unique case (cur_req.swn)
        SWN_PIN3:   per_d = PER_PIN3;
        SWN_CC0:    per_d = PER_CC0;
        SWN_CC1:    per_d = sel.sel_capcmp1_or_i2c ? PER_I2C : PER_CC1;
        SWN_CTMR:   per_d = sel.sel_captimer_or_lines ? PER_LINES : PER_CTMR;
        SWN_SER4:   per_d = sel.sel_serial4_or_pin5 ? PER_PIN5 : PER_SER4;
        SWN_SER3:   per_d = sel.sel_serial3_or_pin4 ? PER_PIN4 : PER_SER3;
        SWN_COLL:   per_d = PER_COLL;
        SWN_DMA0:   per_d = PER_DMA0;
        SWN_DMA1:   per_d = PER_DMA1;
        SWN_KEY:    per_d = PER_KEY;
        SWN_ADC:    per_d = PER_ADC;
        SWN_SER2TX: per_d = PER_SER2TX;
        SWN_SER2RX: per_d = PER_SER2RX;
        SWN_SER0TX: per_d = PER_SER0TX;
        default:    per_d = PER_OTHER;
      endcase
    end
  end

  // Sequencer for breakpoint check, entry fetch and ID read
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_q <= ST_IDLE;
    else if (ce)
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (req_valid)
            state_q <= (req.src == SRC_BRK) ? ST_BRK_CHK : ST_FETCH;
          else if (id_start && FLASH_VERSION)
            state_q <= ST_ID_RD;
        end
        ST_BRK_CHK:
        begin
          if (mem_ack)
            state_q <= ST_FETCH;
        end
        ST_FETCH:
        begin
          if (mem_ack && unit_q == last_unit)
            state_q <= ST_IDLE;
        end
        ST_ID_RD:
        begin
          if (mem_ack && unit_q == ID_LAST_ENTRY)
            state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Latched request and source information
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      req_q          <= '{src: SRC_UND, swn: SWN_BRK};
      periph_src_q   <= PER_NONE;
      wdg_osc_stop_q <= 1'b0;
    end
    else if (ce && state_q == ST_IDLE && req_valid)
    begin
      req_q        <= req;
      periph_src_q <= per_d;
      if (req.src == SRC_WDG)
        wdg_osc_stop_q <= osc_flag_s;
    end
  end

  // Memory address, width and unit counter
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mem_addr_q <= FIX_RST;
      mem_word_q <= 1'b0;
      unit_q     <= 3'h0;
    end
    else if (ce)
    begin
      if (state_q == ST_IDLE)
      begin
        unit_q <= 3'h0;
        if (req_valid && req.src == SRC_BRK)
        begin
          mem_addr_q <= BRK_FLAG_ADDR;
          mem_word_q <= 1'b0;
        end
        else if (req_valid)
        begin
          mem_addr_q <= entry_addr;
          mem_word_q <= entry_word;
        end
        else if (id_start && FLASH_VERSION)
        begin
          mem_addr_q <= FIX_UND + ENTRY_HI;
          mem_word_q <= 1'b0;
        end
      end
      else if (state_q == ST_BRK_CHK && mem_ack)
      begin
        mem_addr_q <= entry_addr;
        mem_word_q <= entry_word;
      end
      else if (state_q == ST_FETCH && mem_ack)
      begin
        unit_q     <= unit_q + 3'h1;
        mem_addr_q <= mem_addr_q + (mem_word_q ? STEP_WORD : STEP_BYTE);
      end
      else if (state_q == ST_ID_RD && mem_ack)
      begin
        unit_q     <= unit_q + 3'h1;
        mem_addr_q <= mem_addr_q + ENTRY_STEP;
      end
    end
  end

  // Entry assembly and hand-off of the routine start address
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      vec_q          <= 32'h0000_0000;
      handler_addr_q <= FIX_RST;
      done_q         <= 1'b0;
    end
    else if (ce)
    begin
      done_q <= 1'b0;
      if (fetch_ack)
      begin
        vec_q <= vec_d;
        if (unit_q == last_unit)
        begin
          // Upper bits of the entry (reserved nibble, ID byte) are not used
          handler_addr_q <= vec_d[ADDR_W-1:0];
          done_q         <= 1'b1;
        end
      end
    end
  end

  // ID code from the high byte of each fixed entry from FFFDC to FFFF8, reset entry excluded
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      id_code_q  <= 64'h0000_0000_0000_0000;
      id_valid_q <= 1'b0;
    end
    else if (ce)
    begin
      if (state_q == ST_IDLE && id_start && !req_valid)
        id_valid_q <= 1'b0;
      else if (state_q == ST_ID_RD && mem_ack)
      begin
        id_code_q[8*unit_q +: 8] <= mem_rdata[7:0];
        if (unit_q == ID_LAST_ENTRY)
          id_valid_q <= 1'b1;
      end
    end
  end

  // Bytes taken so far for the entry in flight, counted apart from unit_q for the checks
  logic [2:0] bytes_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      bytes_q <= 3'h0;
    else if (ce)
    begin
      if (state_q != ST_FETCH)
        bytes_q <= 3'h0;
      else if (mem_ack)
        bytes_q <= bytes_q + (mem_word_q ? STEP_WORD[2:0] : STEP_BYTE[2:0]);
    end
  end

  // Checks, sampled only on enabled edges
  default clocking cb @(posedge sys_clk iff ce);
  endclocking
  default disable iff (rst);

  sequence s_accept(ivam_src_e s);
    state_q == ST_IDLE && req_valid && req.src == s;
  endsequence

  sequence s_last_ack;
    fetch_ack && unit_q == last_unit;
  endsequence

  AST_ENTRY_UNITS: assert property (
    s_last_ack
      |-> bytes_q + (mem_word_q ? STEP_WORD[2:0] : STEP_BYTE[2:0]) == ENTRY_STEP[2:0])
    else $error("entry finished with wrong unit count");

  AST_DONE_FOLLOWS_LAST: assert property (
    s_last_ack |=> done_q && state_q == ST_IDLE && handler_addr_q == vec_q[19:0])
    else $error("routine address not handed over after last unit");

  AST_DONE_PULSE: assert property (
    done_q |=> !done_q)
    else $error("done held longer than one cycle");

  AST_FIXED_RANGE: assert property (
    state_q == ST_FETCH && req_q.src != SRC_SOFT && req_q.src != SRC_BRK
      |-> mem_addr_q >= FIX_LO && mem_addr_q <= FIX_HI)
    else $error("fixed entry outside fixed table");

  AST_UND_ADDR: assert property (
    s_accept(SRC_UND) |=> mem_addr_q == FIX_UND && mem_word_q)
    else $error("undefined-opcode entry address wrong");

  AST_OVF_ADDR: assert property (
    s_accept(SRC_OVF) |=> mem_addr_q == FIX_OVF)
    else $error("overflow entry address wrong");

  AST_BRK_CHECK: assert property (
    s_accept(SRC_BRK) |=> state_q == ST_BRK_CHK && mem_addr_q == BRK_FLAG_ADDR && !mem_word_q)
    else $error("breakpoint flag byte not read first");

  AST_BRK_RELOC: assert property (
    state_q == ST_BRK_CHK && mem_ack && mem_rdata[7:0] == BRK_RELOC_MARK
      |=> state_q == ST_FETCH && mem_addr_q == vector_base_register)
    else $error("relocated breakpoint not fetched from base");

  AST_RESET_ADDR: assert property (
    s_accept(SRC_RST) |=> mem_addr_q == FIX_RST)
    else $error("reset entry address wrong");

  AST_SOFT_ADDR: assert property (
    s_accept(SRC_SOFT)
      |=> mem_addr_q == $past(vector_base_register) + {12'h000, req_q.swn, 2'b00})
    else $error("relocatable entry not at base plus four n");

  AST_ODD_BYTES: assert property (
    state_q == ST_FETCH
      |-> (unit_q != 3'h0 || mem_word_q == ~mem_addr_q[0]) && (!mem_word_q || !mem_addr_q[0]))
    else $error("access width does not follow address parity");

  AST_SHARED_SEL: assert property (
    s_accept(SRC_SOFT) ##0 req.swn == SWN_SER3
      |=> periph_src_q == ($past(sel.sel_serial3_or_pin4) ? PER_PIN4 : PER_SER3))
    else $error("shared number 9 source not chosen by select");

endmodule // ivam_top

// ==== bench/ivam_mem_model.sv ====
// Purpose: Program memory model serving vector entry reads
// Assumes: Byte content is a fixed formula of the address
// Notes:   Idle read data shows the inverse of the last answer
`timescale 1ns/1ps
module ivam_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        mem_rd_req,
  input  wire logic [19:0] mem_addr_q,
  input  wire logic        mem_word_q,
  input  wire logic [1:0]  wait_cyc,
  input  wire logic        brk_mark,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata
);
  logic [1:0]  wait_q = 2'h0;
  logic [15:0] last_q = 16'h0000;

  // Byte content, with the breakpoint flag byte and reserved nibble set apart
  function automatic logic [7:0] mem_byte(input logic [19:0] a, input logic m);
    logic [7:0] b;
    b = a[7:0] + a[15:8] + 8'h3C;
    if (a == 20'hF_FFFF)
      b = b | 8'h0F;
    if (m && a == 20'hF_FFE7)
      b = 8'hFF;
    return b;
  endfunction

  // Answer after the chosen wait; lowest address goes to the low byte
  assign mem_ack = mem_rd_req && (wait_q == wait_cyc);
  always_comb
  begin
    if (!mem_ack)
      mem_rdata = ~last_q;
    else if (mem_word_q)
      mem_rdata = {mem_byte(mem_addr_q + 20'h0_0001, brk_mark), mem_byte(mem_addr_q, brk_mark)};
    else
      mem_rdata = {~mem_byte(mem_addr_q, brk_mark), mem_byte(mem_addr_q, brk_mark)};
  end

  // Wait counter restarts after every answer
  always @(posedge sys_clk)
  begin
    wait_q <= (!mem_rd_req || mem_ack) ? 2'h0 : wait_q + 2'h1;
    if (mem_ack)
      last_q <= mem_rdata;
  end
endmodule // ivam_mem_model

// ==== bench/ivam_top_tb.sv ====
// Purpose: Self-checking bench for the vector entry fetch block
// Assumes: Zero-wait memory unless a case sets wait states
// Notes:   Table rows first, then hand-written awkward cases
`timescale 1ns/1ps
module ivam_top_tb
  import ivam_pkg::*;
();
  typedef struct {
    ivam_src_e  s;
    logic [5:0] n;
    logic [3:0] sl;
    ivam_per_e  p;
  } ivam_tb_row_s;

  logic        sys_clk, rst, ce, req_valid, osc_stop_detect_flag, id_start, brk_mark;
  logic        mem_rd_req, mem_word_q, mem_ack, busy, done_q, wdg_osc_stop_q, id_valid_q;
  logic [1:0]  wait_cyc;
  logic [15:0] mem_rdata;
  logic [19:0] vector_base_register, mem_addr_q, handler_addr_q, e;
  logic [63:0] id_code_q;
  ivam_req_s   req;
  ivam_sel_s   sel;
  ivam_per_e   periph_src_q;
  int          n_fail = 0;
  int          n_compared = 0;
  int          cyc, k;

  // Inputs beside the peripheral source they should report
  ivam_tb_row_s rows [31] = '{
    '{SRC_UND, 6'h00, 4'h0, PER_NONE}, '{SRC_OVF, 6'h00, 4'h0, PER_NONE},
    '{SRC_ADM, 6'h00, 4'h0, PER_NONE}, '{SRC_SSTEP, 6'h00, 4'h0, PER_NONE},
    '{SRC_WDG, 6'h00, 4'h0, PER_NONE}, '{SRC_DBG, 6'h00, 4'h0, PER_NONE},
    '{SRC_NMI, 6'h00, 4'h0, PER_NONE}, '{SRC_RST, 6'h00, 4'h0, PER_NONE},
    '{SRC_BRK, 6'h00, 4'h0, PER_NONE}, '{SRC_SOFT, 6'h00, 4'h0, PER_BRK},
    '{SRC_SOFT, 6'h01, 4'h0, PER_RSV}, '{SRC_SOFT, 6'h03, 4'h0, PER_RSV},
    '{SRC_SOFT, 6'h04, 4'h0, PER_PIN3}, '{SRC_SOFT, 6'h05, 4'h0, PER_CC0},
    '{SRC_SOFT, 6'h06, 4'h0, PER_CC1}, '{SRC_SOFT, 6'h06, 4'h2, PER_I2C},
    '{SRC_SOFT, 6'h07, 4'h0, PER_CTMR}, '{SRC_SOFT, 6'h07, 4'h1, PER_LINES},
    '{SRC_SOFT, 6'h08, 4'h0, PER_SER4}, '{SRC_SOFT, 6'h08, 4'h4, PER_PIN5},
    '{SRC_SOFT, 6'h09, 4'h0, PER_SER3}, '{SRC_SOFT, 6'h09, 4'h8, PER_PIN4},
    '{SRC_SOFT, 6'h0A, 4'h0, PER_COLL}, '{SRC_SOFT, 6'h0B, 4'h0, PER_DMA0},
    '{SRC_SOFT, 6'h0C, 4'h0, PER_DMA1}, '{SRC_SOFT, 6'h0D, 4'h0, PER_KEY},
    '{SRC_SOFT, 6'h0E, 4'h0, PER_ADC}, '{SRC_SOFT, 6'h0F, 4'h0, PER_SER2TX},
    '{SRC_SOFT, 6'h10, 4'h0, PER_SER2RX}, '{SRC_SOFT, 6'h11, 4'h0, PER_SER0TX},
    '{SRC_SOFT, 6'h3F, 4'h0, PER_OTHER}
  };

  ivam_top #(.FLASH_VERSION(1'b1)) DUT (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .req_valid(req_valid), .req(req),
    .vector_base_register(vector_base_register), .sel(sel),
    .osc_stop_detect_flag(osc_stop_detect_flag), .id_start(id_start),
    .mem_rd_req(mem_rd_req), .mem_addr_q(mem_addr_q), .mem_word_q(mem_word_q),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy), .done_q(done_q),
    .handler_addr_q(handler_addr_q), .periph_src_q(periph_src_q),
    .wdg_osc_stop_q(wdg_osc_stop_q), .id_code_q(id_code_q), .id_valid_q(id_valid_q)
  );

  ivam_mem_model MEM (
    .sys_clk(sys_clk), .mem_rd_req(mem_rd_req), .mem_addr_q(mem_addr_q),
    .mem_word_q(mem_word_q), .wait_cyc(wait_cyc), .brk_mark(brk_mark),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );

  // Expected memory byte and routine address of an entry
  function automatic logic [7:0] mb(input logic [19:0] a);
    return a[7:0] + a[15:8] + 8'h3C;
  endfunction
  function automatic logic [19:0] hdl(input logic [19:0] a);
    logic [7:0] b2;
    b2 = mb(a + 20'h0_0002);
    return {b2[3:0], mb(a + 20'h0_0001), mb(a)};
  endfunction

  // Verdict and end of run
  task automatic complete_run;
    if (n_fail == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask

  // One accepted interrupt; cyc counts edges up to the done cycle
  task automatic do_req(input ivam_src_e s, input logic [5:0] n, input logic [3:0] sl);
    req_valid = 1'b1;
    req = '{src: s, swn: n};
    sel = ivam_sel_s'(sl);
    for (cyc = 1; cyc <= 40; cyc++)
    begin
      tick();
      req_valid = 1'b0;
      if (done_q === 1'b1)
        break;
    end
    if (cyc > 40)
    begin
      n_fail++;
      complete_run();
    end
  endtask

  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Main sequence
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    req_valid = 1'b0;
    req = '{src: SRC_RST, swn: 6'h00};
    vector_base_register = 20'h1_2340;
    sel = '0;
    osc_stop_detect_flag = 1'b0;
    id_start = 1'b0;
    wait_cyc = 2'h0;
    brk_mark = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    foreach (rows[i])
    begin
      if (rows[i].s == SRC_SOFT)
        e = vector_base_register + {12'h000, rows[i].n, 2'b00};
      else
        e = 20'hF_FFDC + {14'h0000, rows[i].s, 2'b00};
      do_req(rows[i].s, rows[i].n, rows[i].sl);
      chk(handler_addr_q, hdl(e));
      chk(periph_src_q, rows[i].p);
      chk(cyc, (rows[i].s == SRC_BRK) ? 4 : 3);
    end
    // Breakpoint moved to the relocatable table
    brk_mark = 1'b1;
    do_req(SRC_BRK, 6'h00, 4'h0);
    chk(handler_addr_q, hdl(vector_base_register));
    brk_mark = 1'b0;
    // Odd base takes the slower byte reads
    vector_base_register = 20'h2_3455;
    do_req(SRC_SOFT, 6'h05, 4'h0);
    chk(handler_addr_q, hdl(20'h2_3469));
    chk(cyc, 5);
    vector_base_register = 20'h1_2340;
    // Shared watchdog vector reports the oscillation flag
    for (k = 0; k < 2; k++)
    begin
      osc_stop_detect_flag = (k == 0);
      repeat (5) tick();
      do_req(SRC_WDG, 6'h00, 4'h0);
      chk(wdg_osc_stop_q, (k == 0));
      chk(handler_addr_q, hdl(20'hF_FFF0));
    end
    // Slow memory, with a second request while busy that must be ignored
    wait_cyc = 2'h2;
    req_valid = 1'b1;
    req = '{src: SRC_SOFT, swn: 6'h04};
    tick();
    do_req(SRC_NMI, 6'h00, 4'h0);
    chk(handler_addr_q, hdl(20'h1_2350));
    chk(cyc, 6);
    repeat (8)
    begin
      tick();
      chk(done_q, 1'b0);
    end
    wait_cyc = 2'h0;
    // Clock enable low freezes a fetch in flight
    req_valid = 1'b1;
    req = '{src: SRC_SOFT, swn: 6'h0E};
    tick();
    req_valid = 1'b0;
    ce = 1'b0;
    repeat (4) tick();
    chk(busy, 1'b1);
    chk(mem_addr_q, 20'h1_2378);
    ce = 1'b1;
    tick();
    tick();
    chk(done_q, 1'b1);
    chk(handler_addr_q, hdl(20'h1_2378));
    // Reset in mid fetch, then a clean fetch
    req_valid = 1'b1;
    req = '{src: SRC_SOFT, swn: 6'h0D};
    tick();
    req_valid = 1'b0;
    rst = 1'b1;
    tick();
    rst = 1'b0;
    chk(busy, 1'b0);
    chk(handler_addr_q, 20'hF_FFFC);
    chk(periph_src_q, PER_NONE);
    do_req(SRC_NMI, 6'h00, 4'h0);
    chk(handler_addr_q, hdl(20'hF_FFF8));
    // Identification code from the fixed entries' high bytes
    id_start = 1'b1;
    tick();
    id_start = 1'b0;
    for (k = 0; k < 100 && id_valid_q !== 1'b1; k++)
      tick();
    if (k >= 100)
    begin
      n_fail++;
      complete_run();
    end
    for (k = 0; k < 8; k++)
      chk(id_code_q[8*k +: 8], mb(20'hF_FFDF + 20'(4 * k)));
    complete_run();
  end
endmodule // ivam_top_tb
